/* verilog/srm_pkg.sv */
package srm_pkg;
   localparam int W = 16;
   localparam int FLUX_W = 32;
   localparam int LUT_AW = 6;
   // clock rate and loop periods
   localparam int CLK_PERIOD_NS = 8;
   localparam int SPEED_PERIOD_NS = 1000000;
   localparam int CUR_PERIOD_NS = 10000;
   localparam int SAMP_PERIOD_NS = 10000;
   localparam int SPEED_DIV_CYC = SPEED_PERIOD_NS / CLK_PERIOD_NS;
   localparam int CUR_DIV_CYC = CUR_PERIOD_NS / CLK_PERIOD_NS;
   localparam int SAMP_DIV_CYC = SAMP_PERIOD_NS / CLK_PERIOD_NS;
   // duty and scaling
   localparam logic [W-1:0] DUTY_FULL = 16'hFFFF;
   localparam logic [W-1:0] DUTY_ZERO = 16'h0000;
   localparam int K_FRAC = 15;
   localparam int R_SHIFT = 8;
   localparam int ADV_SHIFT = 16;
   localparam int GAMMA_SHIFT = 16;
   localparam int DIV_STEPS = 32;
   // regulator gains as right shifts
   localparam int SPD_KP_SH = 2;
   localparam int SPD_KI_SH = 6;
   localparam int CUR_KP_SH = 1;
   localparam int CUR_KI_SH = 4;
   // flux curve shape
   localparam int LUT_KNEE = 32;
   localparam int LUT_SLOPE_LO = 1024;
   localparam int LUT_SLOPE_HI = 256;
   localparam logic [2:0] PHASE_FIRST = 3'b001;
   localparam logic [2:0] PHASE_NONE = 3'b000;
   typedef enum logic [1:0] {ST_OFF, ST_FULL, ST_REG} srm_drive_e;
endpackage : srm_pkg

/* verilog/srm_flux_rom.sv */
`timescale 1ns/1ps
module srm_flux_rom import srm_pkg::*; #(
   parameter int AW = LUT_AW,
   parameter int DW = W
) (
   // clock
   input wire logic CLK,
   // read port
   input wire logic [AW-1:0] ADDR,
   output logic [DW-1:0] DATA
);
   // aligned flux against current: steep, then saturating
   function automatic logic [DW-1:0] curve(input int a);
      int v;
      v = 0;
      if (a < LUT_KNEE) begin
         v = a * LUT_SLOPE_LO;
      end else begin
         v = LUT_KNEE * LUT_SLOPE_LO + (a - LUT_KNEE) * LUT_SLOPE_HI;
      end
      return DW'(v);
   endfunction : curve

   logic [DW-1:0] mem [2**AW];

   always_comb begin
      for (int n = 0; n < 2**AW; n++) begin
         mem[n] = curve(n);
      end
   end

   always_ff @(posedge CLK) begin
      DATA <= mem[ADDR];
   end
endmodule : srm_flux_rom

/* verilog/srm_pi.sv */
`timescale 1ns/1ps
module srm_pi import srm_pkg::*; #(
   parameter int DW = W,
   parameter int KP_SH = 2,
   parameter int KI_SH = 6
) (
   // clock and reset
   input wire logic CLK,
   input wire logic RST_B,
   // control
   input wire logic EN,
   input wire logic CLR,
   input wire logic [DW-1:0] PRESET,
   // loop signals
   input wire logic [DW-1:0] SP,
   input wire logic [DW-1:0] FB,
   output logic [DW-1:0] OUT
);
   localparam logic signed [DW+1:0] MAXV = {2'b00, {DW{1'b1}}};

   function automatic logic signed [DW+1:0] sat(input logic signed [DW+1:0] x);
      if (x < 0) begin
         return '0;
      end
      return (x > MAXV) ? MAXV : x;
   endfunction : sat

   logic signed [DW+1:0] err, integ_reg, integ_next, sum;

   always_comb begin
      err = $signed({2'b00, SP}) - $signed({2'b00, FB});
      integ_next = sat(integ_reg + (err >>> KI_SH));
      sum = sat(integ_next + (err >>> KP_SH));
   end

   // output moves only on its loop tick or on a clear, so it holds for the whole period
   always_ff @(posedge CLK) begin
      if (!RST_B || CLR) begin
         integ_reg <= $signed({2'b00, PRESET});
         OUT <= PRESET;
      end else if (EN) begin
         integ_reg <= integ_next;
         OUT <= sum[DW-1:0];
      end
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B);

   property p_pi_hold;
      !EN && !CLR |=> $stable(OUT);
   endproperty
   a_pi_hold: assert property (p_pi_hold) else $error("regulator output moved off its tick");
endmodule : srm_pi

/* verilog/srm_commutation.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - voltage mode: applied phase voltage constant over each dwell, set from the speed loop at turn-on.
// - phase switching follows estimated rotor position, never elapsed time.
// - voltage mode: speed error (desired minus actual) sets PWM duty.
// - voltage mode: duty latched at turn-on, unchanged for the whole dwell.
// - current mode: current setpoint held for each speed-loop period.
// - current mode: speed regulator turns speed error into current setpoint.
// - current mode: current regulator sets duty, updated at current-loop rate.
// - current mode: newly commutated phase driven at full duty first.
// - current compared to setpoint periodically; regulator enabled once exceeded.
// - regulator owns duty until next commutation; repeats every stroke.
// - phase energized at minimum inductance; inductance taken as constant.
// - rise time is unaligned inductance times current over bus voltage times duty.
// - advance angle is rise time times actual electrical speed.
// - reference flux is angle factor (0..1) times aligned flux at current.
// - aligned magnetization curve kept in a lookup table.
// - flux estimate integrates voltage minus resistance times current from turn-on.
// - estimate cleared at turn-on; voltage and current sampled together periodically.
// - after each flux update, compare against reference at present current.
// - estimate above reference commutates: active phase off, next phase on.
// - flux grows by voltage minus drop once per sample, from stroke start.
// - flux kept divided by sample period; table carries the same scaling.
module srm_commutation import srm_pkg::*; #(
   parameter int SPEED_DIV = SPEED_DIV_CYC,
   parameter int CUR_DIV = CUR_DIV_CYC,
   parameter int SAMP_DIV = SAMP_DIV_CYC
) (
   // clock and reset
   input wire logic CLK,
   input wire logic RST_B,
   // control
   input wire logic RUN,
   input wire logic MODE_CURRENT,
   input wire logic [W-1:0] SPEED_DESIRED,
   input wire logic [W-1:0] SPEED_ACTUAL,
   // motor constants
   input wire logic [W-1:0] R_PHASE,
   input wire logic [W-1:0] K_COMM,
   input wire logic [W-1:0] L_UNALIGNED,
   input wire logic [W-1:0] BUS_VOLTAGE,
   // sampled inverter quantities
   input wire logic signed [W-1:0] PHASE_VOLTAGE,
   input wire logic [W-1:0] PHASE_CURRENT,
   // drive outputs
   output logic [2:0] PHASE_EN,
   output logic [W-1:0] PWM_DUTY,
   output logic CUR_REG_ON,
   output logic COMMUTATE,
   // status
   output logic signed [FLUX_W-1:0] FLUX_EST,
   output logic [W-1:0] ADVANCE_ANGLE,
   output logic [W-1:0] SETPOINT
);
   // tick dividers: speed loop, current loop, flux sampling
   localparam int DIVS [3] = '{SPEED_DIV, CUR_DIV, SAMP_DIV};
   logic [2:0] tick;
   logic spd_tick, cur_tick, samp_tick;

   for (genvar g = 0; g < 3; g++) begin : g_div
      logic [31:0] cnt_reg;
      always_ff @(posedge CLK) begin
         if (!RST_B || cnt_reg == 32'(DIVS[g] - 1)) begin
            cnt_reg <= '0;
         end else begin
            cnt_reg <= cnt_reg + 32'h0000_0001;
         end
      end
      always_ff @(posedge CLK) begin
         tick[g] <= RST_B && (cnt_reg == 32'(DIVS[g] - 1));
      end
   end

   assign spd_tick = tick[0];
   assign cur_tick = tick[1];
   assign samp_tick = tick[2];

   // speed regulator: its output is duty in voltage mode, current setpoint otherwise
   logic [W-1:0] spd_out, cur_out;
   srm_drive_e st_reg, st_next;

   srm_pi #(.DW(W), .KP_SH(SPD_KP_SH), .KI_SH(SPD_KI_SH)) u_speed (
      .CLK(CLK),
      .RST_B(RST_B),
      .EN(spd_tick),
      .CLR(1'b0),
      .PRESET(DUTY_ZERO),
      .SP(SPEED_DESIRED),
      .FB(SPEED_ACTUAL),
      .OUT(spd_out)
   );

   // current regulator is preset to full duty, so takeover is bumpless
   srm_pi #(.DW(W), .KP_SH(CUR_KP_SH), .KI_SH(CUR_KI_SH)) u_current (
      .CLK(CLK),
      .RST_B(RST_B),
      .EN(cur_tick && st_reg == ST_REG),
      .CLR(st_reg != ST_REG),
      .PRESET(DUTY_FULL),
      .SP(spd_out),
      .FB(PHASE_CURRENT),
      .OUT(cur_out)
   );

   // flux pipeline: capture, integrate, compare
   logic signed [W-1:0] u_cap;
   logic [W-1:0] i_cap, lut_data;
   logic s1_vld, s2_vld, comm_now, turn_on;
   logic signed [FLUX_W-1:0] flux_reg, drop, flux_next;
   logic [2*W-1:0] r_prod, k_prod;
   logic [W-1:0] flux_ref;
   logic [2:0] ptr_reg;

   srm_flux_rom #(.AW(LUT_AW), .DW(W)) u_rom (
      .CLK(CLK),
      .ADDR(i_cap[W-1 -: LUT_AW]),
      .DATA(lut_data)
   );

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         u_cap <= '0;
         i_cap <= '0;
      end else if (samp_tick) begin
         u_cap <= PHASE_VOLTAGE;
         i_cap <= PHASE_CURRENT;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         s1_vld <= 1'b0;
         s2_vld <= 1'b0;
      end else begin
         s1_vld <= samp_tick && !turn_on;
         s2_vld <= s1_vld && !turn_on;
      end
   end

   // flux is kept in units of flux per sample period; the table uses the same unit
   always_comb begin
      r_prod = R_PHASE * i_cap;
      drop = $signed({{R_SHIFT{1'b0}}, r_prod[2*W-1:R_SHIFT]});
      flux_next = flux_reg + FLUX_W'(u_cap) - drop;
      k_prod = K_COMM * lut_data;
      flux_ref = k_prod[K_FRAC+W-1:K_FRAC];
   end

   // position, not time, decides when to commutate
   assign comm_now = RUN && st_reg != ST_OFF && s2_vld
                     && flux_reg > $signed({16'h0000, flux_ref});
   assign turn_on = comm_now || (RUN && st_reg == ST_OFF);

   always_ff @(posedge CLK) begin
      if (!RST_B || turn_on) begin
         flux_reg <= '0;
      end else if (s1_vld) begin
         flux_reg <= flux_next;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         ptr_reg <= PHASE_FIRST;
      end else if (comm_now) begin
         ptr_reg <= {ptr_reg[1:0], ptr_reg[2]};
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_B || !RUN) begin
         PHASE_EN <= PHASE_NONE;
      end else if (comm_now) begin
         PHASE_EN <= {ptr_reg[1:0], ptr_reg[2]};
      end else begin
         PHASE_EN <= ptr_reg;
      end
   end

   // drive state
   always_comb begin
      st_next = st_reg;
      unique case (st_reg)
         ST_OFF: st_next = ST_FULL;
         ST_FULL: begin
            if (!comm_now && MODE_CURRENT && cur_tick && PHASE_CURRENT > spd_out) begin
               st_next = ST_REG;
            end
         end
         ST_REG: begin
            if (comm_now) begin
               st_next = ST_FULL;
            end
         end
      endcase
   end

   always_ff @(posedge CLK) begin
      if (!RST_B || !RUN) begin
         st_reg <= ST_OFF;
      end else begin
         st_reg <= st_next;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_B || !RUN) begin
         PWM_DUTY <= DUTY_ZERO;
      end else if (turn_on) begin
         PWM_DUTY <= MODE_CURRENT ? DUTY_FULL : spd_out;
      end else if (MODE_CURRENT && st_reg == ST_REG) begin
         PWM_DUTY <= cur_out;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         COMMUTATE <= 1'b0;
         CUR_REG_ON <= 1'b0;
         FLUX_EST <= '0;
         SETPOINT <= DUTY_ZERO;
      end else begin
         COMMUTATE <= comm_now;
         CUR_REG_ON <= st_next == ST_REG && RUN;
         FLUX_EST <= flux_reg;
         SETPOINT <= spd_out;
      end
   end

   // advance angle: serial divide, one bit per clock, restarted each speed tick
   logic dv_busy;
   logic [5:0] dv_cnt;
   logic [W-1:0] dv_rem, dv_den, dt;
   logic [31:0] dv_quo, num_prod, den_prod, adv_prod;
   logic [W:0] trial;

   always_comb begin
      num_prod = L_UNALIGNED * spd_out;
      den_prod = BUS_VOLTAGE * (MODE_CURRENT ? DUTY_FULL : spd_out);
      trial = {dv_rem, dv_quo[31]};
      dt = (dv_quo[31:W] != '0) ? DUTY_FULL : dv_quo[W-1:0];
      adv_prod = SPEED_ACTUAL * dt;
   end

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         dv_busy <= 1'b0;
         dv_cnt <= '0;
         dv_rem <= '0;
         dv_den <= '0;
         dv_quo <= '0;
         ADVANCE_ANGLE <= '0;
      end else if (!dv_busy) begin
         if (spd_tick) begin
            dv_busy <= 1'b1;
            dv_cnt <= '0;
            dv_rem <= '0;
            dv_quo <= num_prod;
            dv_den <= den_prod[GAMMA_SHIFT+W-1:GAMMA_SHIFT];
         end
      end else if (dv_cnt == 6'(DIV_STEPS)) begin
         dv_busy <= 1'b0;
         ADVANCE_ANGLE <= adv_prod[ADV_SHIFT+W-1:ADV_SHIFT];
      end else begin
         dv_cnt <= dv_cnt + 6'h01;
         if (trial >= {1'b0, dv_den}) begin
            dv_rem <= W'(trial - {1'b0, dv_den});
            dv_quo <= {dv_quo[30:0], 1'b1};
         end else begin
            dv_rem <= trial[W-1:0];
            dv_quo <= {dv_quo[30:0], 1'b0};
         end
      end
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B);

   sequence s_volt_dwell;
      (RUN && !MODE_CURRENT) ##1 (RUN && !MODE_CURRENT && !$past(turn_on));
   endsequence
   sequence s_cross;
      s2_vld && RUN && st_reg != ST_OFF && flux_reg > $signed({16'h0000, flux_ref});
   endsequence
   sequence s_takeover;
      st_reg == ST_FULL && MODE_CURRENT && cur_tick && PHASE_CURRENT > spd_out && !comm_now && RUN;
   endsequence

   property p_dwell_duty;
      s_volt_dwell |-> $stable(PWM_DUTY);
   endproperty
   a_dwell_duty: assert property (p_dwell_duty) else $error("duty moved inside a voltage dwell");
   property p_full_start;
      turn_on && MODE_CURRENT |=> PWM_DUTY == DUTY_FULL && st_reg == ST_FULL;
   endproperty
   a_full_start: assert property (p_full_start) else $error("new phase not at full duty");
   property p_takeover;
      s_takeover |=> st_reg == ST_REG ##0 CUR_REG_ON;
   endproperty
   a_takeover: assert property (p_takeover) else $error("current regulator not enabled");
   property p_owns;
      st_reg == ST_REG && RUN && !comm_now |=> st_reg == ST_REG;
   endproperty
   a_owns: assert property (p_owns) else $error("regulator dropped before commutation");
   property p_cross;
      s_cross |-> comm_now ##1 COMMUTATE ##0 flux_reg == 0;
   endproperty
   a_cross: assert property (p_cross) else $error("crossing did not commutate");
   property p_cause;
      comm_now |-> $past(samp_tick, 2) && flux_reg == $past(flux_next) && flux_reg > $signed({16'h0000, flux_ref});
   endproperty
   a_cause: assert property (p_cause) else $error("commutation without flux crossing");
   property p_rotate;
      comm_now |=> $past(ptr_reg) == {ptr_reg[0], ptr_reg[2:1]} && $onehot(PHASE_EN);
   endproperty
   a_rotate: assert property (p_rotate) else $error("phase did not step in order");
   property p_accum;
      s1_vld && !turn_on |=> flux_reg == $past(flux_next);
   endproperty
   a_accum: assert property (p_accum) else $error("flux did not accumulate");
   property p_setpoint;
      !spd_tick |=> $stable(spd_out);
   endproperty
   a_setpoint: assert property (p_setpoint) else $error("setpoint moved off speed tick");

   // sample path and duty mux: a stale pair or a wrong path would skew every stroke
   property p_sample;
      samp_tick |=> u_cap == $past(PHASE_VOLTAGE) && i_cap == $past(PHASE_CURRENT);
   endproperty
   a_sample: assert property (p_sample) else $error("voltage and current not captured together");
   property p_clear;
      turn_on |=> flux_reg == 0;
   endproperty
   a_clear: assert property (p_clear) else $error("flux not cleared at turn-on");
   property p_reg_duty;
      RUN && MODE_CURRENT && st_reg == ST_REG && !turn_on |=> PWM_DUTY == $past(cur_out);
   endproperty
   a_reg_duty: assert property (p_reg_duty) else $error("duty not taken from current regulator");
   property p_volt_path;
      RUN && !MODE_CURRENT && st_reg == ST_FULL |=> st_reg != ST_REG;
   endproperty
   a_volt_path: assert property (p_volt_path) else $error("current regulator engaged in voltage mode");
endmodule : srm_commutation

/* verification/srm_inverter_model.sv */
`timescale 1ns/1ps
module srm_inverter_model import srm_pkg::*; (
   // clock
   input wire logic CLK,
   // drive from the block
   input wire logic [2:0] PHASE_EN,
   input wire logic [W-1:0] PWM_DUTY,
   input wire logic [W-1:0] BUS_VOLTAGE,
   // bench override: fixed samples instead of the winding model
   input wire logic HOLD,
   input wire logic signed [W-1:0] U_FIX,
   input wire logic [W-1:0] I_FIX,
   // sampled quantities
   output logic signed [W-1:0] PHASE_VOLTAGE,
   output logic [W-1:0] PHASE_CURRENT
);
   logic [2:0] en_reg = 3'b000;
   logic [W-1:0] i_reg = 16'h0000;
   logic [31:0] u_full;
   // flat inductance: current ramps with duty and only resets to zero when PHASE_EN changes, so a stalled duty stalls the flux too
   always_ff @(posedge CLK) begin
      en_reg <= PHASE_EN;
      if (PHASE_EN != en_reg) begin
         i_reg <= 16'h0000;
      end else if (i_reg < 16'hFC00) begin
         i_reg <= i_reg + (PWM_DUTY >> 6);
      end
   end
   assign u_full = 32'(BUS_VOLTAGE) * 32'(PWM_DUTY);
   // an unpowered phase sees the bus reversed, not a stale level
   assign PHASE_VOLTAGE = HOLD ? U_FIX : (PHASE_EN == 3'b000 ? -$signed(BUS_VOLTAGE) : $signed(u_full[31:16]));
   assign PHASE_CURRENT = HOLD ? I_FIX : i_reg;
endmodule : srm_inverter_model

/* verification/sr_motor_sensorless_commutation_tb.sv */
`timescale 1ns/1ps
module sr_motor_sensorless_commutation_tb import srm_pkg::*;;
   localparam int SPD = 200;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic run = 1'b1;
   logic mode_current = 1'b1;
   logic hold = 1'b1;
   logic [W-1:0] speed_desired = 16'h0000;
   logic [W-1:0] speed_actual = 16'h0100;
   logic [W-1:0] k_comm = 16'h8000;
   logic [W-1:0] r_phase = 16'h0001;
   logic [W-1:0] bus_voltage = 16'h0200;
   logic signed [W-1:0] phase_voltage;
   logic [W-1:0] phase_current, pwm_duty, advance_angle, setpoint, sp_q;
   logic [2:0] phase_en;
   logic cur_reg_on, commutate;
   logic signed [FLUX_W-1:0] flux_est;
   int failures = 0;
   int n_compared = 0;
   int cyc = 0;
   int sp_chg = 0;

   always #4 clk = ~clk;

   // short loop periods keep a stroke to about 800 to 2300 cycles
   srm_commutation #(.SPEED_DIV(SPD), .CUR_DIV(20), .SAMP_DIV(10)) u_dut (
      .CLK(clk), .RST_B(rst_b), .RUN(run), .MODE_CURRENT(mode_current),
      .SPEED_DESIRED(speed_desired), .SPEED_ACTUAL(speed_actual),
      .R_PHASE(r_phase), .K_COMM(k_comm), .L_UNALIGNED(16'h0100), .BUS_VOLTAGE(bus_voltage),
      .PHASE_VOLTAGE(phase_voltage), .PHASE_CURRENT(phase_current),
      .PHASE_EN(phase_en), .PWM_DUTY(pwm_duty), .CUR_REG_ON(cur_reg_on), .COMMUTATE(commutate),
      .FLUX_EST(flux_est), .ADVANCE_ANGLE(advance_angle), .SETPOINT(setpoint));

   // fixed samples: drop is 16'h4000 >> 8 = 64, so flux climbs 100 per sample
   srm_inverter_model u_inv (
      .CLK(clk), .PHASE_EN(phase_en), .PWM_DUTY(pwm_duty), .BUS_VOLTAGE(bus_voltage),
      .HOLD(hold), .U_FIX(16'sh00A4), .I_FIX(16'h4000),
      .PHASE_VOLTAGE(phase_voltage), .PHASE_CURRENT(phase_current));

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (setpoint !== sp_q) begin
         sp_chg <= sp_chg + 1;
      end
      sp_q <= setpoint;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic summarize;
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : summarize

   task automatic cfg(input logic mode, input logic hld, input logic [W-1:0] k, input logic [W-1:0] des);
      @(negedge clk);
      mode_current = mode;
      hold = hld;
      k_comm = k;
      speed_desired = des;
      rst_b = 1'b0;
      repeat (5) @(negedge clk);
      chk(phase_en, 0);
      chk(pwm_duty, 0);
      chk(flux_est, 0);
      chk(setpoint, 0);
      rst_b = 1'b1;
      @(negedge clk);
      chk(phase_en, 1);
      chk(pwm_duty, mode ? DUTY_FULL : DUTY_ZERO);
   endtask : cfg

   // delta of zero skips the flux arithmetic checks
   task automatic strokes(input int n_str, input logic [31:0] delta, input logic [31:0] ref_f);
      logic [31:0] last;
      logic [W-1:0] prev_duty;
      logic saw_reg;
      logic saw_drop;
      int n;
      for (int s = 1; s <= n_str; s++) begin
         last = 32'h0;
         saw_reg = 1'b0;
         saw_drop = 1'b0;
         n = 0;
         do begin
            prev_duty = pwm_duty;
            @(posedge clk);
            #1;
            n++;
            saw_reg = saw_reg | (cur_reg_on === 1'b1);
            saw_drop = saw_drop | (mode_current && pwm_duty !== DUTY_FULL);
            if (delta != 0 && flux_est !== last && flux_est !== 0) begin
               chk(flux_est - last, delta);
               last = flux_est;
            end
            if (!mode_current && commutate !== 1'b1) begin
               chk(pwm_duty, prev_duty);
            end
         end while (commutate !== 1'b1 && n < 4000);
         chk(n < 4000, 1);
         if (delta != 0) begin
            chk(last > ref_f, 1);
            chk(last <= ref_f + delta, 1);
         end
         chk(phase_en, 3'b001 << (s % 3));
         chk(pwm_duty, mode_current ? DUTY_FULL : setpoint);
         chk(saw_reg, mode_current);
         chk(saw_drop, mode_current);
         @(posedge clk);
         #1;
         chk(flux_est, 0);
         chk(cur_reg_on, 0);
      end
   endtask : strokes

   task automatic t_takeover;
      int n;
      cfg(1'b1, 1'b0, 16'h8000, 16'h1000);
      n = 0;
      while (cur_reg_on !== 1'b1 && n < 40) begin
         chk(pwm_duty, DUTY_FULL);
         @(posedge clk);
         #1;
         n++;
      end
      chk(n < 40, 1);
      chk(phase_current > setpoint, 1);
      @(negedge clk);
      hold = 1'b1;
      strokes(1, 0, 0);
   endtask : t_takeover

   initial begin
      #400000;
      failures++;
      summarize();
   end

   initial begin
      cfg(1'b1, 1'b1, 16'h8000, 16'h0000);
      strokes(3, 100, 32'h0000_4000);
      cfg(1'b1, 1'b1, 16'h4000, 16'h0000);
      strokes(3, 100, 32'h0000_2000);
      // doubled resistance: drop is 128, so flux climbs 36 per sample
      @(negedge clk);
      r_phase = 16'h0002;
      cfg(1'b1, 1'b1, 16'h4000, 16'h0000);
      strokes(3, 36, 32'h0000_2000);
      @(negedge clk);
      r_phase = 16'h0001;
      cfg(1'b0, 1'b1, 16'h4000, 16'h1000);
      strokes(3, 100, 32'h0000_2000);
      chk(setpoint > 0, 1);
      t_takeover();
      @(negedge clk);
      speed_actual = 16'h0000;
      repeat (250) @(negedge clk);
      chk(advance_angle, 0);
      chk(sp_chg <= cyc / SPD + 10, 1);
      summarize();
   end
endmodule : sr_motor_sensorless_commutation_tb
